// file: inc/eisl_pkg.sv
package eisl_pkg;
    localparam int EISL_CH = 8;
    localparam int EISL_ADDR_W = 8;
    localparam int EISL_FIELD_W = 2;
    localparam int EISL_RISE_OFS = 1;
    localparam int EISL_FALL_OFS = 0;
    localparam int EISL_SENSE_W = 16;
    localparam int EISL_WORD_LSB = 2;

    localparam logic [7:0] EISL_OFF_SENSE = 8'h00;
    localparam logic [7:0] EISL_OFF_STATUS = 8'h04;
    localparam logic [7:0] EISL_OFF_ENABLE = 8'h08;

    localparam logic [15:0] EISL_SENSE_RST = 16'h0000;
    localparam logic [7:0] EISL_STATUS_RST = 8'h00;
    localparam logic [7:0] EISL_ENABLE_RST = 8'h00;
    localparam logic [7:0] EISL_PIN_IDLE = 8'hFF;

    localparam logic [1:0] EISL_RESP_OKAY = 2'h0;
    localparam logic [1:0] EISL_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EISL_LOW_LEVEL = 2'h0,
        EISL_FALL_EDGE = 2'h1,
        EISL_RISE_EDGE = 2'h2,
        EISL_BOTH_EDGE = 2'h3
    } eisl_sense_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } eisl_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } eisl_axi_rsp_t;
endpackage

// file: src/eisl_sync.sv
module eisl_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] s2_r;
    logic [W-1:0] s2_nxt;

    always_comb begin
        s1_nxt = d;
        s2_nxt = s1_r;
    end

    // pins idle high, so reset to high avoids a false falling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= '1;
            s2_r <= '1;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign q = s2_r;
endmodule

// file: src/eisl_chan.sv
module eisl_chan (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input eisl_pkg::eisl_sense_t code,
    input wire logic enable,
    input wire logic clear,
    output logic flag,
    output logic req
);
    import eisl_pkg::*;

    logic prev_r;
    logic prev_nxt;
    logic flag_r;
    logic flag_nxt;
    logic req_r;
    logic req_nxt;
    logic fall;
    logic rise;
    logic evt;

    always_comb begin
        prev_nxt = pin;
        fall = prev_r & ~pin;
        rise = ~prev_r & pin;
        unique case (code)
            EISL_LOW_LEVEL: evt = ~pin;
            EISL_FALL_EDGE: evt = fall;
            EISL_RISE_EDGE: evt = rise;
            EISL_BOTH_EDGE: evt = fall | rise;
        endcase
        // a set in the clearing cycle wins
        flag_nxt = evt | (flag_r & ~clear);
        if (code == EISL_LOW_LEVEL) begin
            req_nxt = enable & ~pin;
        end else begin
            req_nxt = enable & flag_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_r <= 1'b1;
            flag_r <= 1'b0;
            req_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            flag_r <= flag_nxt;
            req_r <= req_nxt;
        end
    end

    assign flag = flag_r;
    assign req = req_r;

    a_fall_sets_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        code == EISL_FALL_EDGE && prev_r && !pin |=> flag_r)
        else $error("falling edge did not set flag");
    a_rise_sets_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        code == EISL_RISE_EDGE && !prev_r && pin |=> flag_r)
        else $error("rising edge did not set flag");
    a_both_edges_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        code == EISL_BOTH_EDGE && prev_r != pin |=> flag_r)
        else $error("edge in both-edge mode did not set flag");
    a_level_drives_req: assert property (
        @(posedge clk) disable iff (!rst_n)
        code == EISL_LOW_LEVEL && enable |=> req_r == !$past(pin))
        else $error("level request does not follow pin");
    a_disable_blocks_req: assert property (
        @(posedge clk) disable iff (!rst_n)
        !enable |=> !req_r)
        else $error("request passed while disabled");
    a_clear_drops_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        clear && !evt |=> !flag_r)
        else $error("written zero did not clear flag");
    a_flag_stays_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        flag_r && !clear |=> flag_r)
        else $error("flag dropped without a clear");
    a_edge_no_spurious: assert property (
        @(posedge clk) disable iff (!rst_n)
        code == EISL_RISE_EDGE && !flag_r && !(pin && !prev_r)
        |=> !flag_r)
        else $error("flag set without a rising edge");
    a_edge_uses_sample: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> prev_r == $past(pin))
        else $error("edge detector compares wrong samples");
endmodule

// file: src/eisl_top.sv
// Functional notes
// - channel 7 code: bit 15 rise, 14 fall
// - channel 6 code: bit 13 rise, 12 fall
// - channel 5 code: bit 11 rise, 10 fall
// - channel 4 code: bit 9 rise, 8 fall
// - channel 3 code: bit 7 rise, 6 fall
// - channel 2 code: bit 5 rise, 4 fall
// - channel 1 code: bit 3 rise, 2 fall
// - channel 0 code: bit 1 rise, 0 fall
// - code 00: request while pin low
// - code 01: request on falling edge
// - code 10: request on rising edge
// - code 11: request on either edge
// - sense bits reset zero, all read/write
// - enable bit gates request to processor
// - status flag: writing 0 clears, 1 ignored
module eisl_top (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input eisl_pkg::eisl_axi_req_t S_AXI_REQ,
    output eisl_pkg::eisl_axi_rsp_t S_AXI_RSP,
    input wire logic [7:0] EXT_INT_PIN,
    output logic [7:0] IRQ_REQ
);
    import eisl_pkg::*;

    eisl_axi_rsp_t rsp_r;
    eisl_axi_rsp_t rsp_nxt;
    logic aw_have_r;
    logic aw_have_nxt;
    logic [7:0] aw_addr_r;
    logic [7:0] aw_addr_nxt;
    logic w_have_r;
    logic w_have_nxt;
    logic [31:0] w_data_r;
    logic [31:0] w_data_nxt;
    logic [3:0] w_strb_r;
    logic [3:0] w_strb_nxt;
    logic [15:0] sense_r;
    logic [15:0] sense_nxt;
    logic [7:0] enable_r;
    logic [7:0] enable_nxt;
    logic [7:0] clear_vec;
    logic [7:0] pin_sync;
    logic [7:0] flags;
    logic [7:0] reqs;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic commit;
    logic hit_sense;
    logic hit_status;
    logic hit_enable;
    logic rd_sense;
    logic rd_status;
    logic rd_enable;

    eisl_sync #(
        .W(EISL_CH)
    ) u_sync (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .d(EXT_INT_PIN),
        .q(pin_sync)
    );

    // write address and data are taken independently, in either order
    always_comb begin
        aw_fire = S_AXI_REQ.awvalid & rsp_r.awready;
        w_fire = S_AXI_REQ.wvalid & rsp_r.wready;
        ar_fire = S_AXI_REQ.arvalid & rsp_r.arready;
        commit = aw_have_r & w_have_r & ~rsp_r.bvalid;
        hit_sense = aw_addr_r[7:EISL_WORD_LSB] ==
                    EISL_OFF_SENSE[7:EISL_WORD_LSB];
        hit_status = aw_addr_r[7:EISL_WORD_LSB] ==
                     EISL_OFF_STATUS[7:EISL_WORD_LSB];
        hit_enable = aw_addr_r[7:EISL_WORD_LSB] ==
                     EISL_OFF_ENABLE[7:EISL_WORD_LSB];
        rd_sense = S_AXI_REQ.araddr[7:EISL_WORD_LSB] ==
                   EISL_OFF_SENSE[7:EISL_WORD_LSB];
        rd_status = S_AXI_REQ.araddr[7:EISL_WORD_LSB] ==
                    EISL_OFF_STATUS[7:EISL_WORD_LSB];
        rd_enable = S_AXI_REQ.araddr[7:EISL_WORD_LSB] ==
                    EISL_OFF_ENABLE[7:EISL_WORD_LSB];
    end

    always_comb begin
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt = w_have_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        if (aw_fire) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = S_AXI_REQ.awaddr;
        end
        if (w_fire) begin
            w_have_nxt = 1'b1;
            w_data_nxt = S_AXI_REQ.wdata;
            w_strb_nxt = S_AXI_REQ.wstrb;
        end
        if (commit) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
        end
    end

    // register updates on a committed write
    always_comb begin
        sense_nxt = sense_r;
        enable_nxt = enable_r;
        clear_vec = 8'h00;
        if (commit && hit_sense) begin
            if (w_strb_r[0]) begin
                sense_nxt[7:0] = w_data_r[7:0];
            end
            if (w_strb_r[1]) begin
                sense_nxt[15:8] = w_data_r[15:8];
            end
        end
        if (commit && hit_status && w_strb_r[0]) begin
            clear_vec = ~w_data_r[7:0];
        end
        if (commit && hit_enable && w_strb_r[0]) begin
            enable_nxt = w_data_r[7:0];
        end
    end

    always_comb begin
        rsp_nxt = rsp_r;
        rsp_nxt.awready = ~aw_have_nxt;
        rsp_nxt.wready = ~w_have_nxt;
        if (rsp_r.bvalid && S_AXI_REQ.bready) begin
            rsp_nxt.bvalid = 1'b0;
        end
        if (commit) begin
            rsp_nxt.bvalid = 1'b1;
            if (hit_sense || hit_status || hit_enable) begin
                rsp_nxt.bresp = EISL_RESP_OKAY;
            end else begin
                rsp_nxt.bresp = EISL_RESP_SLVERR;
            end
        end
        if (rsp_r.rvalid && S_AXI_REQ.rready) begin
            rsp_nxt.rvalid = 1'b0;
        end
        rsp_nxt.arready = ~rsp_nxt.rvalid & ~ar_fire;
        if (ar_fire) begin
            rsp_nxt.rvalid = 1'b1;
            rsp_nxt.arready = 1'b0;
            rsp_nxt.rresp = EISL_RESP_OKAY;
            if (rd_sense) begin
                rsp_nxt.rdata = {16'h0000, sense_r};
            end else if (rd_status) begin
                rsp_nxt.rdata = {24'h000000, flags};
            end else if (rd_enable) begin
                rsp_nxt.rdata = {24'h000000, enable_r};
            end else begin
                rsp_nxt.rdata = 32'h00000000;
                rsp_nxt.rresp = EISL_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            rsp_r <= '0;
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_have_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            sense_r <= EISL_SENSE_RST;
            enable_r <= EISL_ENABLE_RST;
        end else begin
            rsp_r <= rsp_nxt;
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r <= w_have_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            sense_r <= sense_nxt;
            enable_r <= enable_nxt;
        end
    end

    // spurious flags after a sense change are left for software to clear
    genvar n;
    generate
        for (n = 0; n < EISL_CH; n++) begin : g_ch
            eisl_chan u_chan (
                .clk(CLOCK),
                .rst_n(RESET_N),
                .pin(pin_sync[n]),
                .code(eisl_sense_t'({
                    sense_r[n*EISL_FIELD_W+EISL_RISE_OFS],
                    sense_r[n*EISL_FIELD_W+EISL_FALL_OFS]})),
                .enable(enable_r[n]),
                .clear(clear_vec[n]),
                .flag(flags[n]),
                .req(reqs[n])
            );
        end
    endgenerate

    assign S_AXI_RSP = rsp_r;
    assign IRQ_REQ = reqs;

    a_sense_reset_zero: assert property (
        @(posedge CLOCK)
        !RESET_N |=> sense_r == EISL_SENSE_RST)
        else $error("sense register not zero after reset");
    a_req_reset_low: assert property (
        @(posedge CLOCK)
        !RESET_N |=> IRQ_REQ == 8'h00)
        else $error("request high after reset");

    a_sense_write_full: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        commit && hit_sense && w_strb_r[1:0] == 2'h3
        |=> sense_r == $past(w_data_r[15:0]))
        else $error("sense write not stored");
    a_sense_held_idle: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        !(commit && hit_sense) |=> $stable(sense_r))
        else $error("sense changed without a write");
    a_sense_read_back: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        ar_fire && rd_sense
        |=> rsp_r.rvalid && rsp_r.rdata == {16'h0000, $past(sense_r)})
        else $error("sense read data wrong");
    a_status_read: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        ar_fire && rd_status
        |=> rsp_r.rdata == {24'h000000, $past(flags)})
        else $error("status read data wrong");
    a_status_keeps_ones: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        commit && hit_status && w_strb_r[0]
        |=> (flags & $past(flags & w_data_r[7:0])) ==
            $past(flags & w_data_r[7:0]))
        else $error("writing one cleared a flag");
    a_enable_write: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        commit && hit_enable && w_strb_r[0]
        |=> enable_r == $past(w_data_r[7:0]))
        else $error("enable write not stored");

    a_unmapped_wr_err: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        commit && !(hit_sense || hit_status || hit_enable)
        |=> rsp_r.bresp == EISL_RESP_SLVERR && $stable(sense_r)
            && $stable(enable_r))
        else $error("unmapped write not refused");
    a_unmapped_rd_err: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        ar_fire && !(rd_sense || rd_status || rd_enable)
        |=> rsp_r.rresp == EISL_RESP_SLVERR && rsp_r.rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_write_answer: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        commit |=> rsp_r.bvalid)
        else $error("write not answered");
    a_aw_ready_low: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        aw_have_r |-> !rsp_r.awready)
        else $error("write address taken while one is held");
    a_w_ready_low: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        w_have_r |-> !rsp_r.wready)
        else $error("write data taken while one is held");
    a_ar_blocked: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        rsp_r.rvalid |-> !rsp_r.arready)
        else $error("read address taken while data pending");
    a_bvalid_holds: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        rsp_r.bvalid && !S_AXI_REQ.bready
        |=> rsp_r.bvalid && $stable(rsp_r.bresp))
        else $error("write response dropped early");
    a_rvalid_holds: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        rsp_r.rvalid && !S_AXI_REQ.rready
        |=> rsp_r.rvalid && $stable(rsp_r.rdata))
        else $error("read data dropped early");

    a_req_gated_enable: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        (IRQ_REQ & ~$past(enable_r)) == 8'h00)
        else $error("request on a disabled channel");

    c_fall_event: cover property (@(posedge CLOCK) disable iff (!RESET_N)
        sense_r[1:0] == 2'h1 && $rose(flags[0]));
    c_both_event: cover property (@(posedge CLOCK) disable iff (!RESET_N)
        sense_r[15:14] == 2'h3 && $rose(flags[7]));
    c_sense_write: cover property (@(posedge CLOCK) disable iff (!RESET_N)
        commit && hit_sense);
    c_status_clear: cover property (@(posedge CLOCK) disable iff (!RESET_N)
        commit && hit_status && flags != 8'h00);
    c_level_event: cover property (@(posedge CLOCK) disable iff (!RESET_N)
        sense_r[1:0] == 2'h0 && enable_r[0] && IRQ_REQ[0]);
endmodule

// file: test/eisl_pin_model.sv
module eisl_pin_model (
    input wire logic CLOCK,
    input wire logic [7:0] level,
    output logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // board pins idle high through pull-ups; levels change after an edge
    initial pins = 8'hFF;
    always @(posedge CLOCK) begin
        pins <= level;
    end
endmodule

// file: test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import eisl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    eisl_axi_req_t req = '0;
    eisl_axi_rsp_t rsp;
    logic [7:0] lvl = 8'hFF;
    logic [7:0] pins;
    logic [7:0] irq;
    int mismatches = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic [1:0] rs;

    always #4 clk = ~clk;

    eisl_pin_model pm (.CLOCK(clk), .level(lvl), .pins(pins));
    eisl_top uut (.CLOCK(clk), .RESET_N(rst_n), .S_AXI_REQ(req),
        .S_AXI_RSP(rsp), .EXT_INT_PIN(pins), .IRQ_REQ(irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic hang();
        mismatches++;
        print_verdict();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        bit ta, tw, tb;
        int i;
        ta = 0;
        tw = 0;
        tb = 0;
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (i = 0; i < 50 && !tb; i++) begin
            @(negedge clk);
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tb = rsp.bvalid;
            r = rsp.bresp;
            @(posedge clk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tb) req.bready <= 1'b0;
        end
        if (!tb) hang();
    endtask

    task automatic rdw(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        bit ta, tr;
        int i;
        tr = 0;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (i = 0; i < 50 && !tr; i++) begin
            @(negedge clk);
            ta = req.arvalid && rsp.arready;
            tr = rsp.rvalid;
            d = rsp.rdata;
            r = rsp.rresp;
            @(posedge clk);
            if (ta) req.arvalid <= 1'b0;
            if (tr) req.rready <= 1'b0;
        end
        if (!tr) hang();
    endtask

    task automatic drive_pins(input logic [7:0] v);
        @(posedge clk);
        lvl <= v;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_regs();
        rdw(EISL_OFF_SENSE, rd, rs);
        check(rd, 32'h0);
        check({30'h0, rs}, {30'h0, EISL_RESP_OKAY});
        rdw(EISL_OFF_STATUS, rd, rs);
        check(rd, 32'h0);
        check({24'h0, irq}, 32'h0);
        wr(EISL_OFF_SENSE, 32'hFFFFA5C3, rs);
        check({30'h0, rs}, {30'h0, EISL_RESP_OKAY});
        rdw(EISL_OFF_SENSE, rd, rs);
        check(rd, 32'h0000A5C3);
        wr(EISL_OFF_SENSE, 32'h00005A3C, rs);
        rdw(EISL_OFF_SENSE, rd, rs);
        check(rd, 32'h00005A3C);
        wr(8'h0C, 32'h1, rs);
        check({30'h0, rs}, {30'h0, EISL_RESP_SLVERR});
        rdw(8'h0C, rd, rs);
        check({30'h0, rs}, {30'h0, EISL_RESP_SLVERR});
        check(rd, 32'h0);
        $display("test regs done");
    endtask

    // channel n gets code (n+k)%4; ph 0 after fall, 1 after clear, 2 rise
    function automatic logic [7:0] exp_irq(input int k, input int ph);
        logic [7:0] e;
        int c;
        for (int n = 0; n < 8; n++) begin
            c = (n + k) % 4;
            e[n] = ph == 0 ? c != 2 : ph == 1 ? c == 0 : c >= 2;
        end
        return e;
    endfunction

    function automatic logic [31:0] sense_of(input int k);
        logic [31:0] s;
        s = 32'h0;
        for (int n = 0; n < 8; n++) s[2*n+:2] = 2'((n + k) % 4);
        return s;
    endfunction

    task automatic t_modes();
        for (int k = 0; k < 4; k++) begin
            wr(EISL_OFF_ENABLE, 32'h0, rs);
            wr(EISL_OFF_SENSE, sense_of(k), rs);
            wr(EISL_OFF_STATUS, 32'h0, rs);
            wr(EISL_OFF_ENABLE, 32'hFF, rs);
            drive_pins(8'h00);
            check({24'h0, irq}, {24'h0, exp_irq(k, 0)});
            rdw(EISL_OFF_STATUS, rd, rs);
            check(rd, {24'h0, exp_irq(k, 0)});
            wr(EISL_OFF_STATUS, 32'h0, rs);
            repeat (2) @(negedge clk);
            check({24'h0, irq}, {24'h0, exp_irq(k, 1)});
            drive_pins(8'hFF);
            check({24'h0, irq}, {24'h0, exp_irq(k, 2)});
        end
        $display("test modes done");
    endtask

    task automatic t_enable();
        wr(EISL_OFF_ENABLE, 32'h0, rs);
        wr(EISL_OFF_SENSE, 32'h0, rs);
        wr(EISL_OFF_STATUS, 32'h0, rs);
        wr(EISL_OFF_ENABLE, 32'h5A, rs);
        drive_pins(8'h00);
        check({24'h0, irq}, 32'h5A);
        drive_pins(8'hFF);
        check({24'h0, irq}, 32'h0);
        rdw(EISL_OFF_STATUS, rd, rs);
        check(rd, 32'hFF);
        wr(EISL_OFF_STATUS, 32'hFF, rs);
        rdw(EISL_OFF_STATUS, rd, rs);
        check(rd, 32'hFF);
        wr(EISL_OFF_STATUS, 32'h0F, rs);
        rdw(EISL_OFF_STATUS, rd, rs);
        check(rd, 32'h0F);
        wr(EISL_OFF_STATUS, 32'h0, rs);
        rdw(EISL_OFF_STATUS, rd, rs);
        check(rd, 32'h0);
        $display("test enable done");
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_modes();
        t_enable();
        print_verdict();
    end
endmodule
